// ### common/ops_defines.svh
// Constants of the OTP security page and status access block
`ifndef OPS_DEFINES_SVH
`define OPS_DEFINES_SVH

// ==========================================================
// Command opcodes
`define OPS_OP_UID            8'h4b
`define OPS_OP_ERASE          8'h44
`define OPS_OP_PROG           8'h42
`define OPS_OP_READ           8'h48
`define OPS_OP_SR1            8'h05
`define OPS_OP_SR2            8'h35
`define OPS_OP_WREN           8'h06
`define OPS_OP_WRDI           8'h04

// ==========================================================
// Byte counts of command phases
`define OPS_ADDR_BYTES        3'h3
`define OPS_UID_DUMMY_BYTES   3'h4
`define OPS_READ_DUMMY_BYTES  3'h1

// ==========================================================
// Security page address encoding
`define OPS_PAGE_HI           8'h00
`define OPS_PAGE_LO           4'h0
`define OPS_PAGE_MIN          4'h1
`define OPS_PAGE_MAX          4'h3
`define OPS_ERASED            8'hff

// ==========================================================
// Status byte field positions
`define OPS_SR1_STATUS_PROTECT_LOW_BIT      7
`define OPS_SR1_SEC_BIT       6
`define OPS_SR1_TB_BIT        5
`define OPS_SR1_BP2_BIT       4
`define OPS_SR1_BP1_BIT       3
`define OPS_SR1_BP0_BIT       2
`define OPS_SR1_WEL_BIT       1
`define OPS_SR1_BUSY_BIT      0
`define OPS_SR2_LOCK_LSB      3

// ==========================================================
// Reset values
`define OPS_WEL_RESET         1'b0
`define OPS_LOCK_RESET        3'h0

// ==========================================================
// Timing
`define OPS_CLK_PERIOD_NS     10
`define OPS_PAGE_WRITE_TIME_US 1000
`define OPS_PAGE_WRITE_CYCLES (`OPS_PAGE_WRITE_TIME_US * 1000 / `OPS_CLK_PERIOD_NS)

`endif

// ### common/ops_link_if.sv
// Byte-level link between the serial front end and the command controller
`default_nettype none
interface ops_link_if;
  import ops_pkg::*;
  logic      rx_stb;
  ops_byte_t rx_byte;
  logic      cs_start;
  logic      cs_end;
  logic      boundary;
  ops_byte_t tx_byte;
  logic      tx_en;
  modport front (output rx_stb, rx_byte, cs_start, cs_end, boundary, input tx_byte, tx_en);
  modport ctrl  (input rx_stb, rx_byte, cs_start, cs_end, boundary, output tx_byte, tx_en);
endinterface
`default_nettype wire

// ### common/ops_pkg.sv
// Types of the OTP security page and status access block
`default_nettype none
package ops_pkg;
  typedef enum logic [2:0] {
    OPS_S_OP    = 3'b000,
    OPS_S_ADDR  = 3'b001,
    OPS_S_DUMMY = 3'b010,
    OPS_S_OUT   = 3'b011,
    OPS_S_DIN   = 3'b100,
    OPS_S_EWAIT = 3'b101,
    OPS_S_IGN   = 3'b110
  } ops_state_e;
  typedef logic [7:0] ops_byte_t;
endpackage
`default_nettype wire

// ### hdl/ops_otp_top.sv
// Security page, unique ID and status read command controller
`default_nettype none
`include "ops_defines.svh"
module ops_otp_top
  import ops_pkg::*;
#(
  parameter int unsigned PAGE_WRITE_CYCLES = `OPS_PAGE_WRITE_CYCLES,
  parameter logic [63:0] UID_VALUE         = 64'h5a5a_0123_4567_a5a5 // Arbitrary value
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       cs_n_i,
  input  wire logic       sck_i,
  input  wire logic       si_i,
  input  wire logic       status_protect_low_i,
  input  wire logic       sector_size_select_i,
  input  wire logic       top_bottom_select_i,
  input  wire logic       block_protect_high_i,
  input  wire logic       block_protect_mid_i,
  input  wire logic       block_protect_low_i,
  input  wire logic [4:0] status_two_misc_i,
  input  wire logic [2:0] page_lock_set_i,
  output logic            so_o,
  output logic            so_oe_n_o,
  output logic            write_enable_latch_o,
  output logic            ready_busy_flag_o,
  output logic [2:0]      page_lock_o
);
  ops_link_if lnk();

  ops_state_e  state_ff;
  ops_byte_t   opcode_ff;
  logic [2:0]  cnt_ff;
  logic [23:0] addr_ff;
  logic [9:0]  ptr_ff;
  logic [7:0]  bptr_ff;
  logic        got_data_ff;
  logic [255:0] mask_ff;
  ops_byte_t   buf_mem [256];
  ops_byte_t   sec_mem [768];
  logic        wel_ff;
  logic [2:0]  lock_ff;
  logic [31:0] busy_cnt_ff;
  logic        exec_erase_ff;
  logic [1:0]  exec_pg_ff;
  logic [8:0]  wptr_ff;
  ops_byte_t   tx_ff;
  ops_byte_t   sr1;
  ops_byte_t   sr2;
  logic [23:0] addr_nxt;
  logic        busy;
  logic        tgt_lock;
  logic        tgt_ok;
  logic        wr_cmd;
  logic        erase_go;
  logic        prog_go;
  logic        write_abort;
  logic        wel_set;
  logic        wel_clr;
  logic [2:0]  dummy_last;

  // ==========================================================
  // Serial front end
  ops_spi_front u_front (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .cs_n_i     (cs_n_i),
    .sck_i      (sck_i),
    .si_i       (si_i),
    .so_o       (so_o),
    .so_oe_n_o  (so_oe_n_o),
    .lnk        (lnk.front)
  );

  // ==========================================================
  // Helpers
  function automatic logic page_ok(input logic [23:0] a);
    page_ok = (a[23:16] == `OPS_PAGE_HI) && (a[11:8] == `OPS_PAGE_LO) &&
              (a[15:12] >= `OPS_PAGE_MIN) && (a[15:12] <= `OPS_PAGE_MAX);
  endfunction

  function automatic logic [9:0] mem_idx(input logic [1:0] pg, input logic [7:0] by);
    mem_idx = {pg - 2'h1, by};
  endfunction

  function automatic ops_byte_t rd_byte(input logic [9:0] p);
    rd_byte = (p[9:8] == 2'h0) ? `OPS_ERASED : sec_mem[mem_idx(p[9:8], p[7:0])];
  endfunction

  function automatic ops_byte_t uid_byte(input logic [2:0] i);
    uid_byte = UID_VALUE[8'd63 - {i, 3'h0} -: 8];
  endfunction

  // ==========================================================
  // Status bytes, sampled live for every repetition
  always_comb begin
    sr1                     = 8'h00;
    sr1[`OPS_SR1_STATUS_PROTECT_LOW_BIT]  = status_protect_low_i;
    sr1[`OPS_SR1_SEC_BIT]   = sector_size_select_i;
    sr1[`OPS_SR1_TB_BIT]    = top_bottom_select_i;
    sr1[`OPS_SR1_BP2_BIT]   = block_protect_high_i;
    sr1[`OPS_SR1_BP1_BIT]   = block_protect_mid_i;
    sr1[`OPS_SR1_BP0_BIT]   = block_protect_low_i;
    sr1[`OPS_SR1_WEL_BIT]   = wel_ff;
    sr1[`OPS_SR1_BUSY_BIT]  = busy;
    sr2                     = {status_two_misc_i[4:3], 3'h0, status_two_misc_i[2:0]};
    sr2[`OPS_SR2_LOCK_LSB +: 3] = lock_ff;
  end

  // ==========================================================
  // Command decisions at select release
  assign busy       = (busy_cnt_ff != 32'h0);
  assign tgt_ok     = page_ok(addr_ff);
  assign tgt_lock   = lock_ff[2'(addr_ff[13:12] - 2'h1)];
  assign wr_cmd     = (opcode_ff == `OPS_OP_ERASE) || (opcode_ff == `OPS_OP_PROG);
  assign addr_nxt   = {addr_ff[15:0], lnk.rx_byte};
  assign dummy_last = (opcode_ff == `OPS_OP_UID) ? `OPS_UID_DUMMY_BYTES - 3'h1
                                                 : `OPS_READ_DUMMY_BYTES - 3'h1;

  assign erase_go = lnk.cs_end && (opcode_ff == `OPS_OP_ERASE) && (state_ff == OPS_S_EWAIT) &&
                    lnk.boundary && wel_ff && tgt_ok && !tgt_lock && !busy;

  assign prog_go = lnk.cs_end && (opcode_ff == `OPS_OP_PROG) && (state_ff == OPS_S_DIN) &&
                   got_data_ff && lnk.boundary && wel_ff && tgt_ok && !tgt_lock && !busy;

  assign write_abort = lnk.cs_end && (state_ff != OPS_S_OP) && wr_cmd &&
                       !erase_go && !prog_go && !busy;

  assign wel_set = lnk.cs_end && (state_ff != OPS_S_OP) && (opcode_ff == `OPS_OP_WREN) &&
                   lnk.boundary && !busy;
  assign wel_clr = lnk.cs_end && (state_ff != OPS_S_OP) && (opcode_ff == `OPS_OP_WRDI) &&
                   lnk.boundary && !busy;

  // ==========================================================
  // Command sequencer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff  <= OPS_S_OP;
      opcode_ff <= 8'h00;
      cnt_ff    <= 3'h0;
      addr_ff   <= 24'h000000;
      ptr_ff    <= 10'h000;
      tx_ff     <= 8'h00;
    end else if (lnk.cs_start) begin
      state_ff <= OPS_S_OP;
      cnt_ff   <= 3'h0;
    end else if (lnk.rx_stb) begin
      case (state_ff)
        OPS_S_OP: begin
          opcode_ff <= lnk.rx_byte;
          cnt_ff    <= 3'h0;
          if (lnk.rx_byte == `OPS_OP_SR1 || lnk.rx_byte == `OPS_OP_SR2) begin
            state_ff <= OPS_S_OUT;
          end else if (busy) begin
            state_ff <= OPS_S_IGN;
          end else if (lnk.rx_byte == `OPS_OP_UID) begin
            state_ff <= OPS_S_DUMMY;
          end else if (lnk.rx_byte == `OPS_OP_ERASE || lnk.rx_byte == `OPS_OP_PROG ||
                       lnk.rx_byte == `OPS_OP_READ) begin
            state_ff <= OPS_S_ADDR;
          end else begin
            state_ff <= OPS_S_IGN;
          end
        end
        OPS_S_ADDR: begin
          addr_ff <= addr_nxt;
          cnt_ff  <= cnt_ff + 3'h1;
          if (cnt_ff == `OPS_ADDR_BYTES - 3'h1) begin
            cnt_ff <= 3'h0;
            case (opcode_ff)
              `OPS_OP_ERASE: state_ff <= OPS_S_EWAIT;
              `OPS_OP_PROG:  state_ff <= OPS_S_DIN;
              default: begin
                state_ff <= OPS_S_DUMMY;
                ptr_ff   <= {addr_nxt[13:12], addr_nxt[7:0]};
              end
            endcase
          end
        end
        OPS_S_DUMMY: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == dummy_last) begin
            state_ff <= OPS_S_OUT;
            if (opcode_ff == `OPS_OP_UID) begin
              tx_ff  <= uid_byte(3'h0);
              cnt_ff <= 3'h1;
            end else begin
              tx_ff  <= rd_byte(ptr_ff);
              ptr_ff <= ptr_ff + 10'h001;
            end
          end
        end
        OPS_S_OUT: begin
          if (opcode_ff == `OPS_OP_UID) begin
            tx_ff  <= uid_byte(cnt_ff);
            cnt_ff <= cnt_ff + 3'h1;
          end else begin
            tx_ff  <= rd_byte(ptr_ff);
            ptr_ff <= ptr_ff + 10'h001;
          end
        end
        OPS_S_EWAIT: state_ff <= OPS_S_IGN;
        OPS_S_DIN:   state_ff <= OPS_S_DIN;
        OPS_S_IGN:   state_ff <= OPS_S_IGN;
        default:     state_ff <= OPS_S_IGN;
      endcase
    end
  end

  assign lnk.tx_en   = (state_ff == OPS_S_OUT);
  assign lnk.tx_byte = (opcode_ff == `OPS_OP_SR1) ? sr1 :
                       (opcode_ff == `OPS_OP_SR2) ? sr2 : tx_ff;

  // ==========================================================
  // Program buffer fill
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bptr_ff     <= 8'h00;
      got_data_ff <= 1'b0;
      mask_ff     <= '0;
    end else if (lnk.rx_stb && state_ff == OPS_S_OP && lnk.rx_byte == `OPS_OP_PROG && !busy) begin
      mask_ff     <= '0;
      got_data_ff <= 1'b0;
    end else if (lnk.rx_stb && state_ff == OPS_S_ADDR && cnt_ff == `OPS_ADDR_BYTES - 3'h1) begin
      bptr_ff <= lnk.rx_byte;
    end else if (lnk.rx_stb && state_ff == OPS_S_DIN) begin
      mask_ff[bptr_ff] <= 1'b1;
      bptr_ff          <= bptr_ff + 8'h01;
      got_data_ff      <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (lnk.rx_stb && state_ff == OPS_S_DIN) begin
      buf_mem[bptr_ff] <= lnk.rx_byte;
    end
  end

  // ==========================================================
  // Self-timed erase and program
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_ff   <= 32'h0;
      exec_erase_ff <= 1'b0;
      exec_pg_ff    <= 2'h0;
      wptr_ff       <= 9'h100;
    end else if (erase_go || prog_go) begin
      busy_cnt_ff   <= PAGE_WRITE_CYCLES;
      exec_erase_ff <= erase_go;
      exec_pg_ff    <= addr_ff[13:12];
      wptr_ff       <= 9'h000;
    end else begin
      if (busy) begin
        busy_cnt_ff <= busy_cnt_ff - 32'h1;
      end
      if (!wptr_ff[8]) begin
        wptr_ff <= wptr_ff + 9'h001;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 768; i++) begin
        sec_mem[i] <= `OPS_ERASED;
      end
    end else if (!wptr_ff[8]) begin
      if (exec_erase_ff) begin
        sec_mem[mem_idx(exec_pg_ff, wptr_ff[7:0])] <= `OPS_ERASED;
      end else if (mask_ff[wptr_ff[7:0]]) begin
        sec_mem[mem_idx(exec_pg_ff, wptr_ff[7:0])] <=
          sec_mem[mem_idx(exec_pg_ff, wptr_ff[7:0])] & buf_mem[wptr_ff[7:0]];
      end
    end
  end

  // ==========================================================
  // Write enable latch and lock flags
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wel_ff <= `OPS_WEL_RESET;
    end else if (busy_cnt_ff == 32'h1) begin
      wel_ff <= 1'b0;
    end else if (write_abort || wel_clr) begin
      wel_ff <= 1'b0;
    end else if (wel_set) begin
      wel_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_ff <= `OPS_LOCK_RESET;
    end else begin
      lock_ff <= lock_ff | page_lock_set_i;
    end
  end

  assign write_enable_latch_o = wel_ff;
  assign ready_busy_flag_o    = busy;
  assign page_lock_o          = lock_ff;
endmodule
`default_nettype wire

// ### hdl/ops_spi_front.sv
// Serial front end: pin synchronisers, clock edge detection and byte shifting
`default_nettype none
module ops_spi_front
  import ops_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  output logic      so_o,
  output logic      so_oe_n_o,
  ops_link_if.front lnk
);
  logic [1:0] cs_n_sync_ff;
  logic [1:0] sck_sync_ff;
  logic [1:0] si_sync_ff;
  logic       cs_act_d_ff;
  logic       sck_d_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] rx_sh_ff;
  logic [6:0] tx_sh_ff;
  logic       drive_ff;
  logic       so_ff;
  logic       rx_stb_ff;
  ops_byte_t  rx_byte_ff;
  logic       cs_act;
  logic       rise;
  logic       fall;

  // ==========================================================
  // Synchronisers and edge detection
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_n_sync_ff <= 2'h3;
      sck_sync_ff  <= 2'h0;
      si_sync_ff   <= 2'h0;
    end else begin
      cs_n_sync_ff <= {cs_n_sync_ff[0], cs_n_i};
      sck_sync_ff  <= {sck_sync_ff[0], sck_i};
      si_sync_ff   <= {si_sync_ff[0], si_i};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_act_d_ff <= 1'b0;
      sck_d_ff    <= 1'b0;
    end else begin
      cs_act_d_ff <= cs_act;
      sck_d_ff    <= sck_sync_ff[1];
    end
  end

  assign cs_act       = !cs_n_sync_ff[1];
  assign rise         = cs_act && sck_sync_ff[1] && !sck_d_ff;
  assign fall         = cs_act && !sck_sync_ff[1] && sck_d_ff;
  assign lnk.cs_start = cs_act && !cs_act_d_ff;
  assign lnk.cs_end   = !cs_act && cs_act_d_ff;
  assign lnk.boundary = (bit_cnt_ff == 3'h0);

  // ==========================================================
  // Receive on rising edges, most significant bit first
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_ff <= 3'h0;
      rx_sh_ff   <= 7'h00;
    end else if (!cs_act) begin
      bit_cnt_ff <= 3'h0;
    end else if (rise) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      rx_sh_ff   <= {rx_sh_ff[5:0], si_sync_ff[1]};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_stb_ff  <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else begin
      rx_stb_ff <= rise && (bit_cnt_ff == 3'h7);
      if (rise && (bit_cnt_ff == 3'h7)) begin
        rx_byte_ff <= {rx_sh_ff, si_sync_ff[1]};
      end
    end
  end

  assign lnk.rx_stb  = rx_stb_ff;
  assign lnk.rx_byte = rx_byte_ff;

  // ==========================================================
  // Transmit on falling edges; a new byte is taken at each byte boundary
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      so_ff    <= 1'b0;
      tx_sh_ff <= 7'h00;
      drive_ff <= 1'b0;
    end else if (!cs_act) begin
      so_ff    <= 1'b0;
      drive_ff <= 1'b0;
    end else if (fall) begin
      if (bit_cnt_ff == 3'h0) begin
        {so_ff, tx_sh_ff} <= lnk.tx_byte;
        drive_ff          <= lnk.tx_en;
      end else begin
        so_ff    <= tx_sh_ff[6];
        tx_sh_ff <= {tx_sh_ff[5:0], 1'b0};
      end
    end
  end

  assign so_o      = so_ff;
  assign so_oe_n_o = !(cs_act && drive_ff);
endmodule
`default_nettype wire

// ### verification/ops_host_model.sv
// Serial bus host model: select, clock and data in, mode 0, MSB first
`default_nettype none
module ops_host_model (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real HALF = 62.5;
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b1;
  end
  // ==========================================================
  // Frame control; the clock rests low between frames
  task automatic open_frame;
    cs_n_o <= 1'b0;
    #HALF;
  endtask
  // Data changes while the clock is low, answer sampled at the rise
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      si_o <= tx[7];
      tx = tx << 1;
      #HALF;
      sck_o <= 1'b1;
      rx = {rx[6:0], so_i};
      #HALF;
      sck_o <= 1'b0;
    end
  endtask
  // Released data line no longer shows the last bit
  task automatic close_frame;
    #HALF;
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    #100;
  endtask
endmodule
`default_nettype wire

// ### verification/ops_otp_props.sv
// Assertion checker for the security page and status access block
`default_nettype none
module ops_otp_props
  import ops_pkg::*;
#(
  parameter int unsigned PAGE_WRITE_CYCLES = 300
) (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       cs_n_i,
  input wire logic [2:0] page_lock_set_i,
  input wire logic       so_oe_n_o,
  input wire logic       write_enable_latch_o,
  input wire logic       ready_busy_flag_o,
  input wire logic [2:0] page_lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Busy length counter
  logic [31:0] busy_cnt_ff;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_ff <= 32'h0;
    end else if (ready_busy_flag_o) begin
      busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end else begin
      busy_cnt_ff <= 32'h0;
    end
  end
  // ==========================================================
  // Properties
  a_oe_off_released: assert property (cs_n_i [*4] |-> so_oe_n_o)
    else $error("Output driven after select release");
  a_oe_needs_select: assert property ($fell(so_oe_n_o) |-> !cs_n_i)
    else $error("Output enabled without select");
  a_busy_span: assert property ($fell(ready_busy_flag_o) |-> busy_cnt_ff == PAGE_WRITE_CYCLES)
    else $error("Busy length wrong");
  a_latch_at_idle: assert property ($fell(ready_busy_flag_o) |-> !write_enable_latch_o)
    else $error("Latch not cleared at end of busy");
  a_busy_needs_latch: assert property ($rose(ready_busy_flag_o) |-> $past(write_enable_latch_o))
    else $error("Busy started without latch");
  a_latch_held_busy: assert property (ready_busy_flag_o |-> write_enable_latch_o)
    else $error("Latch dropped while busy");
  a_lock_sticky: assert property (($past(page_lock_o) & ~page_lock_o) == 3'h0)
    else $error("Lock flag cleared");
  a_lock_takes: assert property (|page_lock_set_i |=>
    (page_lock_o & $past(page_lock_set_i)) == $past(page_lock_set_i))
    else $error("Lock flag not set");
endmodule
bind ops_otp_top ops_otp_props #(.PAGE_WRITE_CYCLES(PAGE_WRITE_CYCLES)) ops_otp_props_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .page_lock_set_i(page_lock_set_i),
  .so_oe_n_o(so_oe_n_o), .write_enable_latch_o(write_enable_latch_o),
  .ready_busy_flag_o(ready_busy_flag_o), .page_lock_o(page_lock_o)
);
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench for the security page and status access block
`default_nettype none
`include "ops_defines.svh"
module tb
  import ops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PWC = 300;
  localparam logic [63:0] UID = 64'h0f1e_2d3c_4b5a_6978; // Arbitrary value
  logic       core_clk_i, rst_i, cs_n, sck, si, so, so_oe_n, write_enable_latch, busy;
  logic [5:0] sr6;
  logic [4:0] misc;
  logic [2:0] lock_set, lock;
  wire        so_w = so_oe_n ? 1'bz : so;
  int         n_fail, n_compared;
  ops_byte_t  rx, v;
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  ops_otp_top #(.PAGE_WRITE_CYCLES(PWC), .UID_VALUE(UID)) ops_otp_top_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .status_protect_low_i(sr6[5]), .sector_size_select_i(sr6[4]), .top_bottom_select_i(sr6[3]),
    .block_protect_high_i(sr6[2]), .block_protect_mid_i(sr6[1]), .block_protect_low_i(sr6[0]),
    .status_two_misc_i(misc), .page_lock_set_i(lock_set), .so_o(so), .so_oe_n_o(so_oe_n),
    .write_enable_latch_o(write_enable_latch), .ready_busy_flag_o(busy), .page_lock_o(lock));
  ops_host_model host_inst (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_w));
  // ==========================================================
  // Compare, access and verdict tasks
  task automatic chk_byte(input ops_byte_t got, input ops_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic snd(input ops_byte_t b);
    host_inst.shift(b, 8, rx);
  endtask
  task automatic sr_read(input ops_byte_t op);
    host_inst.open_frame();
    snd(op);
    snd(8'h00);
    host_inst.close_frame();
  endtask
  task automatic wren;
    host_inst.open_frame();
    snd(`OPS_OP_WREN);
    host_inst.close_frame();
  endtask
  task automatic cmd4(input ops_byte_t op, input logic [23:0] a);
    host_inst.open_frame();
    snd(op);
    snd(a[23:16]);
    snd(a[15:8]);
    snd(a[7:0]);
  endtask
  task automatic rd_cmp(input logic [23:0] a, input ops_byte_t e0, input ops_byte_t e1, input ops_byte_t e2);
    cmd4(`OPS_OP_READ, a);
    snd(8'h00);
    snd(8'h00);
    chk_byte(rx, e0);
    snd(8'h00);
    chk_byte(rx, e1);
    snd(8'h00);
    chk_byte(rx, e2);
    host_inst.close_frame();
  endtask
  task automatic poll;
    sr_read(`OPS_OP_SR1);
    chk_byte(rx, {sr6, 2'b11});
    for (int k = 0; k < 20 && rx[0] === 1'b1; k++)
      sr_read(`OPS_OP_SR1);
    chk_bit(rx[0], 1'b0);
  endtask
  task automatic print_verdict;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400us;
    n_fail++;
    $display("MISMATCH t=%0t timeout", $time);
    print_verdict();
  end
  // ==========================================================
  // Test sequence
  initial begin
    rst_i = 1'b1;
    sr6 = 6'b101101;
    misc = 5'b10110;
    lock_set = 3'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    host_inst.open_frame();
    snd(`OPS_OP_SR1);
    host_inst.shift(8'h00, 4, v);
    @(posedge core_clk_i);
    sr6 <= 6'b010011;
    misc <= 5'b01001;
    host_inst.shift(8'h00, 4, rx);
    chk_byte({v[3:0], rx[3:0]}, 8'hb4);
    snd(8'h00);
    chk_byte(rx, 8'h4c);
    host_inst.close_frame();
    sr_read(`OPS_OP_SR2);
    chk_byte(rx, 8'h41);
    host_inst.open_frame();
    snd(`OPS_OP_UID);
    repeat (4) snd(8'h00);
    for (int i = 0; i < 8; i++) begin
      snd(8'h00);
      chk_byte(rx, UID[63-8*i -: 8]);
    end
    host_inst.close_frame();
    wren();
    sr_read(`OPS_OP_SR1);
    chk_byte(rx, 8'h4e);
    cmd4(`OPS_OP_PROG, 24'h0010fe);
    snd(8'ha5);
    snd(8'h3c);
    host_inst.close_frame();
    poll();
    sr_read(`OPS_OP_SR1);
    chk_byte(rx, 8'h4c);
    wren();
    chk_bit(write_enable_latch, 1'b1);
    host_inst.open_frame();
    snd(`OPS_OP_WRDI);
    host_inst.close_frame();
    chk_bit(write_enable_latch, 1'b0);
    rd_cmp(24'h0010fe, 8'ha5, 8'h3c, 8'hff);
    rd_cmp(24'h0033ff, 8'hff, 8'hff, 8'hff);
    cmd4(`OPS_OP_ERASE, 24'h001000);
    host_inst.close_frame();
    chk_bit(busy, 1'b0);
    wren();
    cmd4(`OPS_OP_ERASE, 24'h001000);
    snd(8'h00);
    host_inst.close_frame();
    chk_bit(busy, 1'b0);
    chk_bit(write_enable_latch, 1'b0);
    wren();
    cmd4(`OPS_OP_ERASE, 24'h004000);
    host_inst.close_frame();
    chk_bit(busy, 1'b0);
    chk_bit(write_enable_latch, 1'b0);
    wren();
    cmd4(`OPS_OP_ERASE, 24'h001077);
    host_inst.close_frame();
    chk_bit(busy, 1'b1);
    poll();
    rd_cmp(24'h0010fe, 8'hff, 8'hff, 8'hff);
    @(posedge core_clk_i);
    lock_set <= 3'h1;
    @(posedge core_clk_i);
    lock_set <= 3'h0;
    @(posedge core_clk_i);
    chk_byte({5'h00, lock}, 8'h01);
    sr_read(`OPS_OP_SR2);
    chk_byte(rx, 8'h49);
    wren();
    cmd4(`OPS_OP_ERASE, 24'h001000);
    host_inst.close_frame();
    chk_bit(busy, 1'b0);
    chk_bit(write_enable_latch, 1'b0);
    cmd4(`OPS_OP_READ, 24'h002000);
    snd(8'h00);
    host_inst.shift(8'h00, 3, v);
    chk_bit(so_oe_n, 1'b0);
    host_inst.close_frame();
    chk_bit(so_oe_n, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
